// ### design/frs_ctrl.sv
// Purpose: fault reaction part of the supply state machine (soft, hard reset, fault hold)
// Assumes: mode requests and init timer come from logic on the same clock
// Notes: monitor indications are asynchronous and pass frs_sync
//
// Operation
// R1: second init timer expiry gives hard reset
// R2: after hard reset release via reset delay
// R3: normal fault: soft reset, controller and core outputs enabled, standby kept
// R4: short undervoltage: delay starts when rails valid
// R5: long undervoltage: init first, then fault hold
// R6: watchdog or error monitor soft reset, delay immediate
// R7: safe one with reset, safe two after delay
// R8: back to normal early keeps safe two high
// R9: standby rail undervoltage moves standby to init
// R10: safe outputs stay low from standby, sleep, wake
// R11: internal supply fault gives hard reset outside fault hold
// R12: sleep fault: soft reset, outputs re-enabled
// R13: wake fault: soft reset, outputs re-enabled
// R14: regulator overvoltage, short or overtemp: fault hold
// R15: reference overvoltage: fault hold
// R16: pre-regulator faults; short only during startup
// R17: third consecutive init failure: fault hold
// R18: bias, monitor overtemp, fuse failure: fault hold
// R19: supply overvoltage: fault hold except standby
// R20: late pre-regulator short only sets flag
// R21: fault hold beats init beats stay
// R22: first init timer expiry gives soft reset
// R23: monitors synchronised, timers count clock cycles

`timescale 1ns/1ps

module frs_ctrl
  import frs_pkg::*;
#(
  parameter int RD_CYC = frs_pkg::RESET_DELAY_CYC,
  parameter int HARD_OFF_CYCLES = frs_pkg::HARD_OFF_CYC,
  parameter int STG_CYC = frs_pkg::SHORT_DETECT_CYC,
  parameter int SS2_CYC = frs_pkg::SS2_STEP_CYC
) (
  input wire logic clk,                                  // internal clock, 200 MHz
  input wire logic rst_b,                                // async reset, active low
  input wire frs_pkg::frs_fault_t fault_pins,            // asynchronous monitor levels
  input wire logic go_normal,                            // request: init or wake to normal
  input wire logic go_standby,                           // request: to standby
  input wire logic go_sleep,                             // request: normal to sleep
  input wire logic go_wake,                              // request: normal or sleep to wake
  input wire logic init_timer_exp,                       // pulse: init timer expired
  input wire logic fault_hold_exit,                      // pulse: leave fault hold
  input wire logic seq_done,                             // power sequencing finished
  input wire logic wd_enable,                            // watchdogs in use
  input wire logic err_enable,                           // error monitoring in use
  input wire frs_pkg::frs_regen_t run_en,                // regulator choice in run states
  input wire logic stby_cfg_on,                          // stored standby regulator config
  input wire logic [frs_pkg::SS2_SEL_W-1:0] ss2_sel,     // second safe delay step count
  input wire logic prereg_flag_clr,                      // pulse: clear pre-reg short flag
  output logic reset_output,                             // reset to controller, low = reset
  output logic safe_state_one,                           // first safe state output
  output logic safe_state_two,                           // second safe state output
  output frs_pkg::frs_regen_t reg_en,                    // regulator enables
  output frs_pkg::frs_state_t state,                     // current state
  output frs_pkg::frs_phase_t phase,                     // reset sequence phase
  output logic prereg_short_flag                         // sticky late pre-reg short
);

  // ****************************************
  // synchronised monitors
  // ****************************************
  logic [$bits(frs_fault_t)-1:0] flt_vec;
  frs_fault_t f;

  frs_sync #(.W($bits(frs_fault_t))) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(fault_pins),
    .sync_out(flt_vec)
  ); // R23

  assign f = frs_fault_t'(flt_vec);

  // ****************************************
  // state registers
  // ****************************************
  frs_state_t state_ff, nxt_state;
  frs_phase_t phase_ff, nxt_phase;
  frs_regen_t reg_en_ff, nxt_reg_en;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, stg_cnt_ff, nxt_stg_cnt, ss2_cnt_ff, nxt_ss2_cnt;
  logic [1:0] init_fail_ff, nxt_init_fail;
  logic rot_ff, nxt_rot, ss1_ff, nxt_ss1, ss2_ff, nxt_ss2, ss2_pend_ff, nxt_ss2_pend;
  logic pflag_ff, nxt_pflag;

  // ****************************************
  // fault classification
  // ****************************************
  logic uv_any, stg_exp, in_startup, run_st, fh_cause, hard_cause, uv_trig, mon_trig;
  logic timer_soft, soft_cause, prereg_set;

  always_comb begin
    // only rails whose regulator is on may report undervoltage
    uv_any = (f.ctrl_uv & reg_en_ff.ctrl) | (f.core_uv & reg_en_ff.core)
           | (f.stby_uv & reg_en_ff.stby);
    stg_exp = uv_any && (stg_cnt_ff == CNT_W'(STG_CYC - 1)); // R5
    in_startup = (state_ff == ST_INIT) && !seq_done;
    run_st = (state_ff == ST_NORMAL) || (state_ff == ST_SLEEP) || (state_ff == ST_WAKE);
    fh_cause = f.ctrl_ov | f.ctrl_stg | f.ctrl_tsd | f.core_ov | f.core_stg
             | f.stby_ov | f.stby_stg // R14
             | f.vref_ov // R15
             | f.prereg_ov | f.prereg_tsd | (f.prereg_stg & in_startup) // R16
             | f.bias_fail | f.mon_tsd | f.fuse_fail // R18
             | (f.vs_ov & (state_ff != ST_STANDBY)) // R19
             | stg_exp // R5
             | (init_timer_exp && state_ff == ST_INIT && init_fail_ff == INIT_FAIL_HOLD); // R17
    hard_cause = f.int_supply // R11
               | (init_timer_exp && state_ff == ST_INIT && init_fail_ff == INIT_FAIL_HARD); // R1
    uv_trig = uv_any && (run_st || state_ff == ST_STANDBY); // R9
    mon_trig = run_st && (((f.wwd_ovf | f.fwd_ovf) & wd_enable) | (f.err_mon & err_enable)); // R6
    timer_soft = init_timer_exp && state_ff == ST_INIT && init_fail_ff == INIT_FAIL_SOFT; // R22
    soft_cause = uv_trig | mon_trig | timer_soft;
    prereg_set = f.prereg_stg && !in_startup && state_ff != ST_FAULT_HOLD
               && state_ff != ST_STANDBY; // R20
  end

  // ****************************************
  // state, reset sequence and regulators
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_init_fail = init_fail_ff;
    nxt_reg_en = reg_en_ff;
    // severity order: fault hold, then hard reset, then soft reset
    if (fh_cause && state_ff != ST_FAULT_HOLD) begin // R21
      nxt_state = ST_FAULT_HOLD;
      nxt_phase = PH_IDLE;
      nxt_reg_en = REGEN_OFF;
    end else if (hard_cause && state_ff != ST_FAULT_HOLD) begin // R11
      nxt_state = ST_INIT;
      nxt_phase = PH_HARD_OFF; // R1
      nxt_cnt = CNT_W'(HARD_OFF_CYCLES - 1);
      nxt_reg_en = REGEN_OFF;
      if (state_ff == ST_INIT && init_timer_exp) begin
        nxt_init_fail = init_fail_ff + 2'h1;
      end
    end else if (soft_cause) begin // R3 R12 R13
      nxt_state = ST_INIT;
      nxt_reg_en.ctrl = 1'h1;
      nxt_reg_en.core = 1'h1;
      // standby regulator keeps its present setting on a soft reset
      nxt_reg_en.stby = reg_en_ff.stby;
      if (timer_soft) begin
        nxt_init_fail = init_fail_ff + 2'h1;
      end
      if (mon_trig && !uv_trig) begin
        nxt_phase = PH_DELAY; // R6
        nxt_cnt = CNT_W'(RD_CYC - 1);
      end else begin
        nxt_phase = PH_WAIT_RAILS; // R4
      end
    end else begin
      case (state_ff)
        ST_INIT: begin
          case (phase_ff)
            PH_HARD_OFF: begin
              if (cnt_ff == '0) begin
                // restart: standby regulator restores its stored config
                nxt_phase = PH_WAIT_RAILS; // R1
                nxt_reg_en = '{ctrl: 1'h1, core: 1'h1, stby: stby_cfg_on};
              end else begin
                nxt_cnt = cnt_ff - CNT_W'(1);
              end
            end
            PH_WAIT_RAILS: begin
              if (!uv_any) begin
                nxt_phase = PH_DELAY; // R2 R4
                nxt_cnt = CNT_W'(RD_CYC - 1);
              end
            end
            PH_DELAY: begin
              if (cnt_ff == '0) begin
                nxt_phase = PH_DONE;
              end else begin
                nxt_cnt = cnt_ff - CNT_W'(1);
              end
            end
            PH_DONE: begin
              if (go_normal) begin
                nxt_state = ST_NORMAL;
                nxt_init_fail = INIT_FAIL_SOFT;
                nxt_reg_en = '{ctrl: 1'h1, core: run_en.core, stby: run_en.stby};
              end
            end
            default: begin
              nxt_phase = PH_WAIT_RAILS;
            end
          endcase
        end
        ST_NORMAL, ST_SLEEP, ST_WAKE: begin
          nxt_reg_en = '{ctrl: 1'h1, core: run_en.core, stby: run_en.stby};
          if (go_standby) begin
            nxt_state = ST_STANDBY;
            nxt_phase = PH_IDLE;
            nxt_reg_en = '{ctrl: 1'h0, core: 1'h0, stby: stby_cfg_on};
          end else if (go_normal && state_ff == ST_WAKE) begin
            nxt_state = ST_NORMAL;
          end else if (go_sleep && state_ff == ST_NORMAL) begin
            nxt_state = ST_SLEEP;
          end else if (go_wake && state_ff != ST_WAKE) begin
            nxt_state = ST_WAKE;
          end
        end
        ST_STANDBY: begin
          nxt_reg_en = '{ctrl: 1'h0, core: 1'h0, stby: stby_cfg_on};
        end
        ST_FAULT_HOLD: begin
          nxt_reg_en = REGEN_OFF;
          if (fault_hold_exit && !fh_cause) begin
            nxt_state = ST_INIT;
            nxt_phase = PH_WAIT_RAILS;
            nxt_reg_en = '{ctrl: 1'h1, core: 1'h1, stby: stby_cfg_on};
          end
        end
        default: begin
          nxt_state = ST_FAULT_HOLD;
          nxt_phase = PH_IDLE;
          nxt_reg_en = REGEN_OFF;
        end
      endcase
    end
    nxt_rot = (nxt_phase == PH_DONE) && (nxt_state != ST_FAULT_HOLD)
              && (nxt_state != ST_STANDBY); // R2
  end

  // ****************************************
  // short detection and safe state outputs
  // ****************************************
  always_comb begin
    // a rail must stay low for the full window before it counts as a short
    nxt_stg_cnt = '0;
    if (uv_any && state_ff != ST_FAULT_HOLD && !stg_exp) begin
      nxt_stg_cnt = stg_cnt_ff + CNT_W'(1); // R5
    end
    nxt_ss1 = (nxt_state == ST_NORMAL); // R7 R10
    nxt_ss2 = 1'h0;
    nxt_ss2_pend = 1'h0;
    nxt_ss2_cnt = ss2_cnt_ff;
    if (nxt_state == ST_NORMAL) begin
      nxt_ss2 = 1'h1; // R8
    end else if (state_ff == ST_NORMAL && nxt_state == ST_INIT && nxt_phase != PH_HARD_OFF) begin
      nxt_ss2_cnt = CNT_W'(SS2_CYC) * CNT_W'(ss2_sel);
      nxt_ss2 = (ss2_sel != '0); // R7
      nxt_ss2_pend = (ss2_sel != '0);
    end else if (ss2_pend_ff && nxt_state == ST_INIT && nxt_phase != PH_HARD_OFF) begin
      if (ss2_cnt_ff > CNT_W'(1)) begin
        nxt_ss2 = 1'h1;
        nxt_ss2_pend = 1'h1;
        nxt_ss2_cnt = ss2_cnt_ff - CNT_W'(1);
      end
    end
    nxt_pflag = prereg_set | (pflag_ff & !prereg_flag_clr); // R20
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_INIT;
      phase_ff <= PH_WAIT_RAILS;
      cnt_ff <= '0;
      init_fail_ff <= INIT_FAIL_SOFT;
      reg_en_ff <= REGEN_OFF;
      rot_ff <= RESET_OUT_RST;
      stg_cnt_ff <= '0;
      ss1_ff <= SAFE_STATE_RST;
      ss2_ff <= SAFE_STATE_RST;
      ss2_pend_ff <= 1'h0;
      ss2_cnt_ff <= '0;
      pflag_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      init_fail_ff <= nxt_init_fail;
      reg_en_ff <= nxt_reg_en;
      rot_ff <= nxt_rot;
      stg_cnt_ff <= nxt_stg_cnt;
      ss1_ff <= nxt_ss1;
      ss2_ff <= nxt_ss2;
      ss2_pend_ff <= nxt_ss2_pend;
      ss2_cnt_ff <= nxt_ss2_cnt;
      pflag_ff <= nxt_pflag;
    end
  end

  assign reset_output = rot_ff;
  assign safe_state_one = ss1_ff;
  assign safe_state_two = ss2_ff;
  assign reg_en = reg_en_ff;
  assign state = state_ff;
  assign phase = phase_ff;
  assign prereg_short_flag = pflag_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // fault hold ignores hard reset causes, so the check starts only outside it
  property p_hard_off;
    hard_cause && !fh_cause && state_ff != ST_FAULT_HOLD |=> (reg_en_ff == REGEN_OFF)
      && !reset_output
      && (phase_ff == PH_HARD_OFF) [*3];
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("hard reset did not cut regulators"); // R1

  property p_release;
    $rose(reset_output) |-> $past(phase_ff) == PH_DELAY && $past(cnt_ff) == '0;
  endproperty
  a_release: assert property (p_release) else $error("reset released outside delay end"); // R2

  property p_soft_normal;
    state_ff == ST_NORMAL && soft_cause && !fh_cause && !hard_cause |=> state_ff == ST_INIT
      && !reset_output && reg_en_ff.ctrl && reg_en_ff.core
      && reg_en_ff.stby == $past(reg_en_ff.stby);
  endproperty
  a_soft_normal: assert property (p_soft_normal) else $error("soft reset from normal wrong"); // R3

  property p_rails_delay;
    state_ff == ST_INIT && phase_ff == PH_WAIT_RAILS && !uv_any && !fh_cause && !hard_cause
      && !soft_cause |=> phase_ff == PH_DELAY && cnt_ff == CNT_W'(RD_CYC - 1);
  endproperty
  a_rails_delay: assert property (p_rails_delay) else $error("delay not started on valid rails"); // R4

  property p_short_hold;
    stg_exp |=> state_ff == ST_FAULT_HOLD ##1 state_ff == ST_FAULT_HOLD || fault_hold_exit;
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("long undervoltage not held"); // R5

  property p_mon_delay;
    mon_trig && !uv_trig && !fh_cause && !hard_cause |=> phase_ff == PH_DELAY
      && cnt_ff == CNT_W'(RD_CYC - 1) && !reset_output;
  endproperty
  a_mon_delay: assert property (p_mon_delay) else $error("monitor reset delay not at once"); // R6

  property p_ss_split;
    state_ff == ST_NORMAL && soft_cause && !fh_cause && !hard_cause && ss2_sel != '0
      |=> !safe_state_one && safe_state_two;
  endproperty
  a_ss_split: assert property (p_ss_split) else $error("safe outputs not split on soft reset"); // R7

  property p_ss2_keep;
    ss2_pend_ff && nxt_state == ST_NORMAL |=> safe_state_two && safe_state_one;
  endproperty
  a_ss2_keep: assert property (p_ss2_keep) else $error("second safe output dropped"); // R8

  property p_ss_low;
    (state_ff == ST_STANDBY || state_ff == ST_SLEEP || state_ff == ST_WAKE)
      ##1 state_ff == ST_INIT |-> !safe_state_one && !safe_state_two;
  endproperty
  a_ss_low: assert property (p_ss_low) else $error("safe outputs rose on entry to init"); // R10

  property p_fault_hold;
    fh_cause |=> state_ff == ST_FAULT_HOLD && reg_en_ff == REGEN_OFF && !reset_output;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault hold not entered"); // R14

  property p_third_fail;
    state_ff == ST_INIT && init_timer_exp && init_fail_ff == INIT_FAIL_HOLD
      |=> state_ff == ST_FAULT_HOLD;
  endproperty
  a_third_fail: assert property (p_third_fail) else $error("third init failure ignored"); // R17

  property p_prereg_flag;
    prereg_set |=> prereg_short_flag && (state_ff != ST_FAULT_HOLD || $past(fh_cause));
  endproperty
  a_prereg_flag: assert property (p_prereg_flag) else $error("late pre-reg short mishandled"); // R20

  c_hard: cover property (state_ff == ST_INIT ##1 phase_ff == PH_HARD_OFF);
  c_soft: cover property (state_ff == ST_NORMAL ##1 state_ff == ST_INIT);
  c_hold: cover property (state_ff == ST_INIT ##1 state_ff == ST_FAULT_HOLD);
  c_ss2: cover property (state_ff == ST_INIT && $fell(safe_state_two));

endmodule : frs_ctrl

// ### design/frs_sync.sv
// Purpose: three stage synchroniser for a vector of asynchronous levels
// Assumes: each bit is an independent slow level
// Notes: a bit changes once the second and third stages agree

`timescale 1ns/1ps

module frs_sync #(
  parameter int W = 1
) (
  input wire logic clk,              // internal clock
  input wire logic rst_b,            // async reset, active low
  input wire logic [W-1:0] async_in, // levels from outside the clock domain
  output logic [W-1:0] sync_out      // filtered, synchronised levels
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  // first stage feeds only the second; filter looks at stages two and three
  always_comb begin
    nxt_out = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule : frs_sync

// ### include/frs_pkg.sv
// Purpose: shared types and constants for the fault reaction state control
// Assumes: 200 MHz internal clock, times kept in ns and turned into cycles
// Notes: least times round up to whole cycles

package frs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_DELAY_NS = 10000;
  localparam int HARD_OFF_NS = 100000;
  localparam int SHORT_DETECT_NS = 2000000;
  localparam int SS2_STEP_NS = 25000;
  localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HARD_OFF_CYC = (HARD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_DETECT_CYC = (SHORT_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS2_STEP_CYC = (SS2_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int SS2_SEL_W = 2;

  // ****************************************
  // reset values and failure counting
  // ****************************************
  localparam logic [1:0] INIT_FAIL_SOFT = 2'h0;
  localparam logic [1:0] INIT_FAIL_HARD = 2'h1;
  localparam logic [1:0] INIT_FAIL_HOLD = 2'h2;
  localparam logic RESET_OUT_RST = 1'h0;
  localparam logic SAFE_STATE_RST = 1'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_INIT, ST_NORMAL, ST_STANDBY, ST_SLEEP, ST_WAKE, ST_FAULT_HOLD
  } frs_state_t;

  typedef enum logic [2:0] {
    PH_IDLE, PH_HARD_OFF, PH_WAIT_RAILS, PH_DELAY, PH_DONE
  } frs_phase_t;

  typedef struct packed {
    logic ctrl;
    logic core;
    logic stby;
  } frs_regen_t;

  localparam frs_regen_t REGEN_OFF = 3'h0;

  // monitor indications, all asynchronous levels, high means fault present
  typedef struct packed {
    logic ctrl_uv;
    logic core_uv;
    logic stby_uv;
    logic ctrl_ov;
    logic ctrl_stg;
    logic ctrl_tsd;
    logic core_ov;
    logic core_stg;
    logic stby_ov;
    logic stby_stg;
    logic vref_ov;
    logic prereg_ov;
    logic prereg_tsd;
    logic prereg_stg;
    logic bias_fail;
    logic mon_tsd;
    logic fuse_fail;
    logic vs_ov;
    logic int_supply;
    logic wwd_ovf;
    logic fwd_ovf;
    logic err_mon;
  } frs_fault_t;

endpackage : frs_pkg

// ### test/frs_ctrl_test.sv
// Purpose: self-checking bench for the fault reaction state control
// Assumes: shortened timers, inputs driven 1 ns after the rising edge
// Notes: every state change must match the oldest expected note

`timescale 1ns/1ps

module frs_ctrl_test;
  import frs_pkg::*;
  localparam int RD = 8;
  localparam int HO = 10;
  localparam int SHORT_TO_GROUND = 40;
  localparam int SS2 = 6;
  logic clk = 1'b0, rst_b = 1'b0, go_normal, go_standby = 1'b0, go_sleep = 1'b0;
  logic go_wake = 1'b0, init_exp = 1'b0, hold_exit = 1'b0, seq_done = 1'b1, cfg_en = 1'b0;
  logic wd_enable = 1'b1, err_enable = 1'b1, stby_cfg_on = 1'b1, flag_clr = 1'b0;
  logic reset_output, safe_state_one, safe_state_two, prereg_short_flag;
  logic watch_ss2 = 1'b0, ss2_drop = 1'b0;
  logic [1:0] ss2_sel = 2'h1;
  logic [7:0] lfsr = 8'h5C;
  frs_fault_t flt = '0;
  frs_regen_t run_en = 3'h7, reg_en, re;
  frs_state_t state, last_st = ST_INIT, exp_st;
  frs_phase_t phase;
  frs_state_t notes[$];
  int bad_count = 0, total_checks = 0;
  int hold_bits[] = '{4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};

  frs_ctrl #(.RD_CYC(RD), .HARD_OFF_CYCLES(HO), .STG_CYC(SHORT_TO_GROUND), .SS2_CYC(SS2)) u_frs_ctrl (
    .clk(clk), .rst_b(rst_b), .fault_pins(flt), .go_normal(go_normal),
    .go_standby(go_standby), .go_sleep(go_sleep), .go_wake(go_wake),
    .init_timer_exp(init_exp), .fault_hold_exit(hold_exit), .seq_done(seq_done),
    .wd_enable(wd_enable), .err_enable(err_enable), .run_en(run_en),
    .stby_cfg_on(stby_cfg_on), .ss2_sel(ss2_sel), .prereg_flag_clr(flag_clr),
    .reset_output(reset_output), .safe_state_one(safe_state_one),
    .safe_state_two(safe_state_two), .reg_en(reg_en), .state(state), .phase(phase),
    .prereg_short_flag(prereg_short_flag));
  frs_mcu_model u_frs_mcu_model (.clk(clk), .rst_b(rst_b), .reset_output(reset_output),
    .cfg_en(cfg_en), .go_normal(go_normal));

  always #2.5 clk = ~clk;

  // ********************************
  // checking
  // ********************************
  task automatic check_state(input frs_state_t e, input frs_state_t s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] state expected %0d seen %0d", e, s);
    end
  endtask : check_state

  task automatic check_bits(input string nm, input logic [2:0] e, input logic [2:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check_bits

  // an unexpected change compares against the old state and fails
  always @(posedge clk) begin
    if (watch_ss2 && safe_state_two !== 1'b1) ss2_drop = 1'b1;
    if (rst_b && state !== last_st) begin
      exp_st = (notes.size() > 0) ? notes.pop_front() : last_st;
      check_state(exp_st, state);
    end
    last_st = state;
  end

  task automatic final_report();
    if (bad_count == 0 && total_checks > 0 && notes.size() == 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #(5 * 20000);
    bad_count++;
    final_report();
  end

  // ********************************
  // stimulus
  // ********************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic go(input frs_state_t s);
    int n;
    n = 0;
    notes.push_back(s);
    while (state !== s && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) check_bits("state_wait", 3'(s), 3'(state));
  endtask : go

  task automatic wait_rel();
    int n;
    n = 0;
    while (reset_output !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check_bits("reset_output", 3'h1, {2'h0, reset_output});
  endtask : wait_rel

  task automatic pulse(input int b, input int n = 3);
    flt[b] = 1'b1;
    cyc(n);
    flt[b] = 1'b0;
  endtask : pulse

  task automatic req(ref logic r);
    r = 1'b1;
    cyc(1);
    r = 1'b0;
  endtask : req

  task automatic to_normal();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    run_en = frs_regen_t'({1'b1, lfsr[1:0]});
    cfg_en = 1'b1;
    go(ST_NORMAL);
    cfg_en = 1'b0;
    cyc(1);
    check_bits("reg_en", 3'(run_en), 3'(reg_en));
    check_bits("safe", 3'h3, {1'b0, safe_state_one, safe_state_two});
  endtask : to_normal

  task automatic leave_hold();
    check_bits("hold_outs", 3'h0, 3'(reg_en) | {reset_output, safe_state_one, safe_state_two});
    cyc(6);
    req(hold_exit);
    go(ST_INIT);
    cyc(1);
    check_bits("reg_en", {2'h3, stby_cfg_on}, 3'(reg_en));
  endtask : leave_hold

  initial begin
    cyc(20);
    rst_b = 1'b1;
    wait_rel();
    check_bits("phase", 3'(PH_DONE), 3'(phase));
    to_normal();
    re = reg_en;
    pulse(2);
    go(ST_INIT);
    check_bits("soft_outs", 3'h1, {reset_output, safe_state_one, safe_state_two});
    check_bits("reg_en", {2'h3, re.stby}, 3'(reg_en));
    cyc(RD - 1);
    check_bits("rst_ss2", 3'h0, {1'b0, reset_output, safe_state_two});
    cyc(1);
    check_bits("reset_output", 3'h1, {2'h0, reset_output});
    ss2_sel = 2'h3;
    to_normal();
    pulse(1);
    go(ST_INIT);
    watch_ss2 = 1'b1;
    to_normal();
    watch_ss2 = 1'b0;
    check_bits("ss2_drop", 3'h0, {2'h0, ss2_drop});
    for (int m = 0; m < 2; m++) begin
      // the first pass starts in normal already; a second note would go stale
      if (m == 1) to_normal();
      if (m == 0) req(go_sleep);
      else req(go_wake);
      go(m == 0 ? ST_SLEEP : ST_WAKE);
      re = reg_en;
      pulse(m == 0 ? 0 : 2);
      go(ST_INIT);
      check_bits("safe", 3'h0, {1'b0, safe_state_one, safe_state_two});
      check_bits("reg_en", {2'h3, re.stby}, 3'(reg_en));
      wait_rel();
    end
    to_normal();
    pulse(21, 4);
    go(ST_INIT);
    check_bits("phase", 3'(PH_WAIT_RAILS), 3'(phase));
    cyc(4);
    check_bits("phase", 3'(PH_DELAY), 3'(phase));
    wait_rel();
    to_normal();
    flt.ctrl_uv = 1'b1;
    go(ST_INIT);
    go(ST_FAULT_HOLD);
    flt.ctrl_uv = 1'b0;
    leave_hold();
    to_normal();
    flt.ctrl_ov = 1'b1;
    pulse(21);
    flt.ctrl_ov = 1'b0;
    go(ST_FAULT_HOLD);
    leave_hold();
    foreach (hold_bits[i]) begin
      to_normal();
      pulse(hold_bits[i]);
      go(ST_FAULT_HOLD);
      leave_hold();
    end
    to_normal();
    req(go_standby);
    go(ST_STANDBY);
    pulse(4);
    cyc(8);
    pulse(19);
    go(ST_INIT);
    check_bits("safe", 3'h0, {1'b0, safe_state_one, safe_state_two});
    check_bits("reg_en", 3'h7, 3'(reg_en));
    wait_rel();
    to_normal();
    pulse(2);
    go(ST_INIT);
    wait_rel();
    req(init_exp);
    check_bits("reset_output", 3'h0, {2'h0, reset_output});
    wait_rel();
    req(init_exp);
    cyc(1);
    check_bits("phase", 3'(PH_HARD_OFF), 3'(phase));
    check_bits("reg_en", 3'h0, 3'(reg_en));
    cyc(HO + 2);
    check_bits("reg_en", {2'h3, stby_cfg_on}, 3'(reg_en));
    wait_rel();
    req(init_exp);
    go(ST_FAULT_HOLD);
    leave_hold();
    to_normal();
    pulse(3);
    go(ST_INIT);
    check_bits("hard_off", {3'(PH_HARD_OFF)}, 3'(phase) | 3'(reg_en));
    wait_rel();
    to_normal();
    pulse(8);
    cyc(6);
    check_bits("flag", 3'h1, {2'h0, prereg_short_flag});
    req(flag_clr);
    cyc(1);
    check_bits("flag", 3'h0, {2'h0, prereg_short_flag});
    pulse(2);
    go(ST_INIT);
    seq_done = 1'b0;
    pulse(8);
    go(ST_FAULT_HOLD);
    seq_done = 1'b1;
    leave_hold();
    final_report();
  end
endmodule : frs_ctrl_test

// ### test/frs_mcu_model.sv
// Purpose: behavioural controller fed and reset by the fault reaction block
// Assumes: controller configures itself a fixed time after its reset is released
// Notes: config only finishes while cfg_en is high, so the bench can stall it

`timescale 1ns/1ps

module frs_mcu_model #(
  parameter int CFG_CYC = 2
) (
  input wire logic clk,          // controller clock
  input wire logic rst_b,        // async reset, active low
  input wire logic reset_output, // reset from supply, low = held in reset
  input wire logic cfg_en,       // bench lets configuration complete
  output logic go_normal         // one pulse per reset release: config done
);
  logic [3:0] cnt_ff;
  logic done_ff;

  // a new reset always restarts configuration, like a real controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
      go_normal <= 1'b0;
    end else begin
      go_normal <= 1'b0;
      if (!reset_output) begin
        cnt_ff <= 4'h0;
        done_ff <= 1'b0;
      end else if (cnt_ff < 4'(CFG_CYC)) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (cfg_en && !done_ff) begin
        go_normal <= 1'b1;
        done_ff <= 1'b1;
      end
    end
  end
endmodule : frs_mcu_model
